// *** rtl/predrv_pkg.sv ***
package predrv_pkg;

   // Serial word and command layout
   localparam int WORD_W = 8;
   localparam int OPC_MSB = 7;
   localparam int OPC_LSB = 6;
   localparam int ARG_W = 6;
   localparam logic [1:0] OPC_NOP = 2'h0;
   localparam logic [1:0] OPC_DEAD_SET = 2'h1;
   localparam logic [1:0] OPC_SIMUL_ALLOW = 2'h2;
   localparam logic [1:0] OPC_SIMUL_BLOCK = 2'h3;
   // Key that must accompany the simultaneous-drive unlock
   localparam logic [5:0] SAFE_KEY = 6'h2a;

   // Reset values of the configuration
   localparam logic [5:0] DEAD_RST = 6'h04;
   localparam logic SIMUL_RST = 1'b0;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCLK_TYP_KHZ = 3000;
   localparam int DEAD_STEP_NS = 80;
   localparam int DEAD_STEP_CYC =
      (DEAD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEAD_CNT_W = 8;

   // Pin synchroniser width
   localparam int PIN_W = 14;
   // Pin rest levels: high-side requests and chip select idle high
   localparam logic [PIN_W-1:0] PIN_RST = 14'h0e04;

   // Three phases of gate drive, bit 0 is phase A
   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } gate_pair_t;

   // Configuration loaded over the serial port
   typedef struct packed {
      logic simul_ok;
      logic [5:0] dead;
   } drive_cfg_t;

endpackage

// *** rtl/serial_port.sv ***
`timescale 1ns/1ps
module serial_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Synchronised serial pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   // Word shifted back to the host
   input wire logic [predrv_pkg::WORD_W-1:0] reply_i,
   // Received word
   output logic [predrv_pkg::WORD_W-1:0] word_o,
   output logic word_valid_o,
   // Serial data out with active-low enable
   output logic sdo_o,
   output logic sdo_oe_n_o
);

   // Frame states
   typedef enum logic {S_IDLE, S_SHIFT} sp_state_t;

   sp_state_t state_q; // Frame state
   logic sclk_q; // Previous serial clock level
   logic [predrv_pkg::WORD_W-1:0] rx_q; // Receive shifter
   logic [predrv_pkg::WORD_W-1:0] tx_q; // Transmit shifter
   logic [3:0] cnt_q; // Bits taken, saturates at one past a word

   // Falling edge of the serial clock
   wire sclk_fall = sclk_q & ~sclk_i;
   wire full_word = (cnt_q == 4'(predrv_pkg::WORD_W));

   // Frame engine: port is live only inside a chip select frame
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= S_IDLE;
         sclk_q <= 1'b0;
         rx_q <= '0;
         tx_q <= '0;
         cnt_q <= 4'h0;
         word_o <= '0;
         word_valid_o <= 1'b0;
         sdo_o <= 1'b0;
         sdo_oe_n_o <= 1'b1;
      end else begin
         sclk_q <= sclk_i;
         word_valid_o <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               // Output released until chip select falls
               sdo_oe_n_o <= 1'b1;
               if (!cs_n_i) begin // Frame opens
                  state_q <= S_SHIFT;
                  cnt_q <= 4'h0;
                  tx_q <= reply_i;
                  sdo_o <= reply_i[predrv_pkg::WORD_W-1];
                  sdo_oe_n_o <= 1'b0;
               end
            end
            S_SHIFT: begin
               if (cs_n_i) begin // Frame closes, whole words only
                  state_q <= S_IDLE;
                  sdo_oe_n_o <= 1'b1;
                  word_o <= rx_q;
                  word_valid_o <= full_word;
               end else if (sclk_fall) begin
                  // Capture on falling edge, MSB arrives first
                  rx_q <= {rx_q[predrv_pkg::WORD_W-2:0], sdi_i};
                  tx_q <= {tx_q[predrv_pkg::WORD_W-2:0], 1'b0};
                  sdo_o <= tx_q[predrv_pkg::WORD_W-2];
                  if (cnt_q <= 4'(predrv_pkg::WORD_W)) begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

endmodule

// *** rtl/predrv_top.sv ***
// What this block does
// - Gates on only while both enables high
// - High-side request input is active low
// - Low-side request input is active high
// - Chip select frames commands, enables serial port
// - Serial data taken on falling clock, MSB first
// - Serial output released until chip select low
// - Status low when switch node below half supply
// - Dead time between complements set over serial
// - Simultaneous drive only after safe command
// - Interlock keeps both sides of phase apart unless simultaneous drive is permitted
`timescale 1ns/1ps
module predrv_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Enable pins
   input wire logic enable_input_one_i,
   input wire logic enable_input_two_i,
   // Direct phase requests
   input wire logic phase_a_high_side_request_n_i,
   input wire logic phase_a_low_side_request_i,
   input wire logic phase_b_high_side_request_n_i,
   input wire logic phase_b_low_side_request_i,
   input wire logic phase_c_high_side_request_n_i,
   input wire logic phase_c_low_side_request_i,
   // Switch node comparators, high when node at or above half supply
   input wire logic phase_a_switch_node_above_half_i,
   input wire logic phase_b_switch_node_above_half_i,
   input wire logic phase_c_switch_node_above_half_i,
   // Serial port pins
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   output logic serial_data_o,
   output logic serial_data_oe_n_o,
   // Phase level status
   output logic phase_a_level_status_o,
   output logic phase_b_level_status_o,
   output logic phase_c_level_status_o,
   // Gate drive commands, bit 0 is phase A
   output logic [2:0] high_side_gate_o,
   output logic [2:0] low_side_gate_o
);

   // Reset release chain
   logic rst_meta_q; // First reset stage
   logic rst_n_q; // Released reset used everywhere else

   // Pin synchroniser stages
   logic [predrv_pkg::PIN_W-1:0] pin_meta_q; // First stage only
   logic [predrv_pkg::PIN_W-1:0] pin_q; // Second stage, safe to read

   // Configuration and drive state
   predrv_pkg::drive_cfg_t cfg_q; // Dead time and simultaneous permit
   predrv_pkg::gate_pair_t gate_q; // Registered gate commands
   predrv_pkg::gate_pair_t gate_d; // Next gate commands
   logic [2:0] status_q; // Registered level status
   logic [predrv_pkg::DEAD_CNT_W-1:0] dead_cnt_q [3]; // Blanking timers

   // Serial port results
   logic [predrv_pkg::WORD_W-1:0] rx_word; // Word from the last closed frame, complete or not
   logic rx_valid; // One-cycle pulse per word
   logic sdo; // Serial data from the shifter
   logic sdo_oe_n; // Active-low output enable

   // Dead time in system clocks from the programmed step count
   function automatic logic [predrv_pkg::DEAD_CNT_W-1:0] dead_cycles(
      input logic [5:0] steps);
      logic [15:0] prod;
      prod = 16'(steps) * 16'(predrv_pkg::DEAD_STEP_CYC);
      return prod[predrv_pkg::DEAD_CNT_W-1:0];
   endfunction

   // Reset: asynchronous assert, released through two flops
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Gather every outside pin for synchronising
   wire [predrv_pkg::PIN_W-1:0] pin_raw = {
      enable_input_one_i, enable_input_two_i,
      phase_c_high_side_request_n_i, phase_b_high_side_request_n_i,
      phase_a_high_side_request_n_i,
      phase_c_low_side_request_i, phase_b_low_side_request_i,
      phase_a_low_side_request_i,
      phase_c_switch_node_above_half_i, phase_b_switch_node_above_half_i,
      phase_a_switch_node_above_half_i,
      chip_select_n_i, serial_clk_i, serial_data_i};

   // Two-flop synchroniser on all pins, both stages idle at rest levels
   // Chip select resets high so no frame opens as reset lifts
   always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pin_meta_q <= predrv_pkg::PIN_RST;
         pin_q <= predrv_pkg::PIN_RST;
      end else begin
         pin_meta_q <= pin_raw;
         pin_q <= pin_meta_q;
      end
   end

   // Named views of the synchronised pins
   wire en_one = pin_q[13];
   wire en_two = pin_q[12];
   wire [2:0] hs_req_n = pin_q[11:9];
   wire [2:0] ls_req = pin_q[8:6];
   wire [2:0] node_above = pin_q[5:3];
   wire cs_n = pin_q[2];
   wire sclk = pin_q[1];
   wire sdi = pin_q[0];

   // Both enables must be high for any gate to turn on
   wire drive_ok = en_one & en_two;
   // High-side requests are active low
   wire [2:0] hs_req = ~hs_req_n;
   // Low-side requests are active high
   wire [2:0] ls_want = ls_req;

   // Serial framing and shifting; host clock rate set by the bench host model
   serial_port u_serial (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n_q),
      .cs_n_i(cs_n),
      .sclk_i(sclk),
      .sdi_i(sdi),
      .reply_i({cfg_q.simul_ok, drive_ok, cfg_q.dead}),
      .word_o(rx_word),
      .word_valid_o(rx_valid),
      .sdo_o(sdo),
      .sdo_oe_n_o(sdo_oe_n)
   );

   // Command decode
   wire [1:0] opc = rx_word[predrv_pkg::OPC_MSB:predrv_pkg::OPC_LSB];
   wire [predrv_pkg::ARG_W-1:0] arg = rx_word[predrv_pkg::ARG_W-1:0];
   wire cmd_dead = rx_valid & (opc == predrv_pkg::OPC_DEAD_SET);
   // Unlock needs both the opcode and the key
   wire cmd_allow = rx_valid & (opc == predrv_pkg::OPC_SIMUL_ALLOW) &
      (arg == predrv_pkg::SAFE_KEY);
   wire cmd_block = rx_valid & (opc == predrv_pkg::OPC_SIMUL_BLOCK);

   // Configuration registers
   always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cfg_q.dead <= predrv_pkg::DEAD_RST;
         cfg_q.simul_ok <= predrv_pkg::SIMUL_RST;
      end else begin
         // Dead time programmed over the serial port
         if (cmd_dead) begin
            cfg_q.dead <= arg;
         end
         // Simultaneous drive only after the safe command
         if (cmd_allow) begin
            cfg_q.simul_ok <= 1'b1;
         end else if (cmd_block) begin
            cfg_q.simul_ok <= 1'b0;
         end
      end
   end

   // Per-phase interlock and blanking
   for (genvar p = 0; p < 3; p++) begin : g_phase
      // Blanking timer has run out
      wire blank_done = (dead_cnt_q[p] == '0);
      // Interlock: neither side may start while the other is on
      wire hs_clear = ~ls_want[p] & ~gate_q.low[p] & blank_done;
      wire ls_clear = ~hs_req[p] & ~gate_q.high[p] & blank_done;
      // Turn-on needs enables, a request and a clear path or the permit
      wire hs_on = drive_ok & hs_req[p] &
         (cfg_q.simul_ok | hs_clear);
      wire ls_on = drive_ok & ls_want[p] &
         (cfg_q.simul_ok | ls_clear);
      // A side that is already on stays on while enabled and still requested, unless the other side is requested without the permit
      assign gate_d.high[p] = hs_on | (drive_ok & hs_req[p] &
         gate_q.high[p] & (cfg_q.simul_ok | ~ls_want[p]));
      assign gate_d.low[p] = ls_on | (drive_ok & ls_want[p] &
         gate_q.low[p] & (cfg_q.simul_ok | ~hs_req[p]));
      // Any side turning off starts a blanking interval
      wire turn_off = (gate_q.high[p] & ~gate_d.high[p]) |
         (gate_q.low[p] & ~gate_d.low[p]);

      // Blanking timer, reloaded by each turn-off
      always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
         if (!rst_n_q) begin
            dead_cnt_q[p] <= '0;
         end else if (turn_off) begin
            dead_cnt_q[p] <= dead_cycles(cfg_q.dead);
         end else if (!blank_done) begin
            dead_cnt_q[p] <= dead_cnt_q[p] - 8'h01;
         end
      end
   end

   // Gate and status outputs
   always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         gate_q <= '0;
         status_q <= 3'h0;
      end else begin
         gate_q <= gate_d;
         // Status follows the half-supply comparator
         status_q <= node_above;
      end
   end

   // Outputs come straight from flops
   assign high_side_gate_o = gate_q.high;
   assign low_side_gate_o = gate_q.low;
   assign phase_a_level_status_o = status_q[0];
   assign phase_b_level_status_o = status_q[1];
   assign phase_c_level_status_o = status_q[2];
   assign serial_data_o = sdo;
   assign serial_data_oe_n_o = sdo_oe_n;

endmodule

// *** dv/host_spi_model.sv ***
`timescale 1ns/1ps
module host_spi_model (
   // Reply from the device
   input wire logic sdo_i,
   // Serial pins toward the device
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   // Clock stands still low outside frames
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // Framed transfer of n bits, 320 ns serial period
   task automatic xfer(input logic [7:0] w, input int n,
                       output logic [7:0] r);
      r = 8'h00;
      cs_n_o = 1'b0;
      #160;
      for (int i = 0; i < n; i++) begin
         sdi_o = w[7-i];
         sclk_o = 1'b1;
         #160;
         r = {r[6:0], sdo_i};
         sclk_o = 1'b0;
         #160;
      end
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #400;
   endtask
endmodule

// *** dv/predrv_asserts.sv ***
`timescale 1ns/1ps
module predrv_asserts (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // Watched inputs
   input wire logic enable_input_one_i,
   input wire logic enable_input_two_i,
   input wire logic phase_a_high_side_request_n_i,
   input wire logic phase_a_low_side_request_i,
   input wire logic phase_a_switch_node_above_half_i,
   input wire logic chip_select_n_i,
   // Watched outputs
   input wire logic serial_data_o,
   input wire logic serial_data_oe_n_o,
   input wire logic phase_a_level_status_o,
   input wire logic [2:0] high_side_gate_o,
   input wire logic [2:0] low_side_gate_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic [2:0] up_q; // Cycles since reset, saturating
   logic permit_q; // Permit bit seen in the last reply
   logic en_w;
   assign en_w = enable_input_one_i & enable_input_two_i;
   // Track settle time and the reported permit
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         up_q <= 3'h0;
         permit_q <= 1'b0;
      end else begin
         if (up_q != 3'h7) up_q <= up_q + 3'h1;
         if (!serial_data_oe_n_o && $past(serial_data_oe_n_o, 2))
            permit_q <= serial_data_o;
      end
   end
   AST_GATES_NEED_EN: assert property ((!en_w)[*4] |->
      high_side_gate_o == 3'h0 && low_side_gate_o == 3'h0)
      else $error("gate on without both enables");
   AST_HS_LOW_ACTIVE: assert property (high_side_gate_o[0] |->
      !$past(phase_a_high_side_request_n_i, 3) ||
      !$past(phase_a_high_side_request_n_i, 4))
      else $error("high side on without low request");
   AST_LS_HIGH_ACTIVE: assert property (low_side_gate_o[0] |->
      $past(phase_a_low_side_request_i, 3) ||
      $past(phase_a_low_side_request_i, 4))
      else $error("low side on without high request");
   AST_STATUS_FOLLOWS: assert property (up_q == 3'h7 ##0
      $stable(phase_a_switch_node_above_half_i)[*5] |->
      phase_a_level_status_o == phase_a_switch_node_above_half_i)
      else $error("status differs from comparator");
   AST_SDO_RELEASED: assert property (chip_select_n_i[*5] |->
      serial_data_oe_n_o) else $error("serial out driven outside frame");
   AST_SDO_IN_FRAME: assert property ($fell(serial_data_oe_n_o) |->
      !chip_select_n_i) else $error("serial out driven without select");
   AST_NO_OVERLAP: assert property (!permit_q |->
      (high_side_gate_o & low_side_gate_o) == 3'h0)
      else $error("both sides on without permit");
   AST_DEAD_GAP: assert property ($fell(high_side_gate_o[0]) &&
      !permit_q |-> (!low_side_gate_o[0])[*2])
      else $error("low side on inside dead time");
   cover property ($rose(low_side_gate_o[0]));
   cover property (permit_q && high_side_gate_o[0] && low_side_gate_o[0]);
   cover property ($fell(serial_data_oe_n_o));
endmodule
bind predrv_top predrv_asserts u_predrv_asserts (.*);

// *** dv/predrv_top_tb_top.sv ***
`timescale 1ns/1ps
module predrv_top_tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] en = 2'h0; // Enable pins, bit 0 is the first
   logic [2:0] hs_n = 3'h7; // High-side requests, idle high
   logic [2:0] ls = 3'h0; // Low-side requests
   logic [2:0] above = 3'h0; // Comparator inputs
   logic cs_n, sclk, sdi, sdo, oe_n;
   logic [2:0] st, hg, lg;
   int errors = 0;
   int num_checks = 0;
   always #20 clk = ~clk;
   host_spi_model u_host_spi_model (.sdo_i(sdo), .cs_n_o(cs_n),
      .sclk_o(sclk), .sdi_o(sdi));
   predrv_top u_predrv_top (.sys_clk_i(clk), .rst_b_i(rst_b),
      .enable_input_one_i(en[0]), .enable_input_two_i(en[1]),
      .phase_a_high_side_request_n_i(hs_n[0]),
      .phase_a_low_side_request_i(ls[0]),
      .phase_b_high_side_request_n_i(hs_n[1]),
      .phase_b_low_side_request_i(ls[1]),
      .phase_c_high_side_request_n_i(hs_n[2]),
      .phase_c_low_side_request_i(ls[2]),
      .phase_a_switch_node_above_half_i(above[0]),
      .phase_b_switch_node_above_half_i(above[1]),
      .phase_c_switch_node_above_half_i(above[2]),
      .chip_select_n_i(cs_n), .serial_clk_i(sclk), .serial_data_i(sdi),
      .serial_data_o(sdo), .serial_data_oe_n_o(oe_n),
      .phase_a_level_status_o(st[0]), .phase_b_level_status_o(st[1]),
      .phase_c_level_status_o(st[2]),
      .high_side_gate_o(hg), .low_side_gate_o(lg));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Serial frame through the host model
   task automatic spi(input logic [7:0] w, input int n,
                      output logic [7:0] r);
      u_host_spi_model.xfer(w, n, r);
   endtask
   // Blanking from high-side fall to low-side rise on phase A
   task automatic gap_of(output int g);
      ls = 3'h0;
      hs_n = 3'h6;
      cyc(20);
      hs_n = 3'h7;
      ls = 3'h1;
      for (int w = 0; w < 50 && hg[0] !== 1'b0; w++) cyc(1);
      for (g = 0; g < 100 && lg[0] !== 1'b1; g++) cyc(1);
      ls = 3'h0;
      cyc(10);
   endtask
   task automatic t_enable();
      hs_n = 3'h6;
      for (int k = 0; k < 4; k++) begin
         en = k[1:0];
         cyc(16);
         chk(hg === ((k == 3) ? 3'h1 : 3'h0), "enable gating");
      end
      hs_n = 3'h0;
      cyc(16);
      chk(hg === 3'h7, "high sides on when low");
      hs_n = 3'h7;
      ls = 3'h7;
      cyc(16);
      chk(hg === 3'h0 && lg === 3'h7, "low sides on when high");
      ls = 3'h0;
      cyc(16);
      $display("t_enable done");
   endtask
   task automatic t_status();
      for (int k = 0; k < 8; k++) begin
         above = k[2:0];
         cyc(8);
         chk(st === k[2:0], "phase status level");
      end
      $display("t_status done");
   endtask
   task automatic t_dead();
      int g4, g1;
      logic [7:0] r;
      gap_of(g4);
      spi({predrv_pkg::OPC_DEAD_SET, 6'h01}, 8, r);
      gap_of(g1);
      chk(g1 >= 2, "short dead time kept");
      chk(g4 - g1 === (int'(predrv_pkg::DEAD_RST) - 1) *
          predrv_pkg::DEAD_STEP_CYC, "dead time step");
      spi({predrv_pkg::OPC_DEAD_SET, predrv_pkg::DEAD_RST}, 8, r);
      $display("t_dead done");
   endtask
   task automatic t_serial();
      logic [7:0] r;
      spi(8'h00, 8, r);
      chk(r === {1'b0, 1'b1, predrv_pkg::DEAD_RST}, "reply word");
      chk(oe_n === 1'b1, "serial out released");
      hs_n = 3'h6;
      ls = 3'h1;
      spi({predrv_pkg::OPC_SIMUL_ALLOW, 6'h15}, 8, r);
      cyc(30);
      chk((hg & lg) === 3'h0, "overlap kept apart");
      // Seven bits that would complete an unlock word if taken
      spi({1'b0, predrv_pkg::OPC_SIMUL_ALLOW, predrv_pkg::SAFE_KEY[5:1]},
          7, r);
      cyc(30);
      chk((hg & lg) === 3'h0, "short frame ignored");
      hs_n = 3'h7;
      ls = 3'h0;
      spi({predrv_pkg::OPC_SIMUL_ALLOW, predrv_pkg::SAFE_KEY}, 8, r);
      spi(8'h00, 8, r);
      chk(r[7] === 1'b1, "permit reported");
      hs_n = 3'h6;
      ls = 3'h1;
      cyc(30);
      chk(hg[0] === 1'b1 && lg[0] === 1'b1, "overlap permitted");
      spi({predrv_pkg::OPC_SIMUL_BLOCK, 6'h00}, 8, r);
      cyc(30);
      chk((hg & lg) === 3'h0, "overlap blocked again");
      $display("t_serial done");
   endtask
   // Hang guard
   initial begin
      #400000;
      errors++;
      close_out();
   end
   initial begin
      cyc(4);
      rst_b = 1'b1;
      cyc(6);
      t_enable();
      t_status();
      t_dead();
      t_serial();
      close_out();
   end
endmodule
